/* pkg/pldt_pkg.sv */
package pldt_pkg;
   // lane geometry
   localparam int LANES        = 2;
   localparam int DATA_W       = 32;
   localparam int K_W          = 4;
   localparam int DBG_W        = 320;
   localparam int LANE_STRIDE  = 160;
   // debug bit positions, lane 0 (lane 1 adds the stride)
   localparam int POS_TXDATA   = 0;
   localparam int POS_TXK      = 32;
   localparam int POS_TXSKIP   = 36;
   localparam int POS_TXSYNC   = 37;
   localparam int POS_TXBLK    = 39;
   localparam int POS_DETLB    = 40;
   localparam int POS_TXIDLE   = 41;
   localparam int POS_COMPL    = 42;
   localparam int POS_RXPOL    = 43;
   localparam int POS_PWR      = 44;
   localparam int POS_RXDATA   = 46;
   localparam int POS_RXK      = 78;
   localparam int POS_RXSKIP   = 82;
   localparam int POS_RXSYNC   = 83;
   localparam int POS_RXBLK    = 85;
   localparam int POS_RXVALID  = 86;
   localparam int POS_DONE     = 87;
   localparam int POS_RXIDLE   = 88;
   localparam int POS_RXSTAT   = 89;
   localparam int POS_RATE     = 92;
   // receive status codes
   localparam logic [2:0] RXST_OK    = 3'h0;
   localparam logic [2:0] RXST_SKPAD = 3'h1;
   localparam logic [2:0] RXST_SKPRM = 3'h2;
   localparam logic [2:0] RXST_DET   = 3'h3;
   localparam logic [2:0] RXST_DECER = 3'h4;
   localparam logic [2:0] RXST_OVF   = 3'h5;
   localparam logic [2:0] RXST_UNF   = 3'h6;
   // sync header, power-down, rate codes
   localparam logic [1:0] SYNC_OS    = 2'h1;
   localparam logic [1:0] SYNC_DATA  = 2'h2;
   localparam logic [1:0] PWR_ON     = 2'h0;
   localparam logic [1:0] PWR_IDLE   = 2'h1;
   localparam logic [1:0] PWR_LOOP   = 2'h2;
   localparam logic [1:0] PWR_BAD    = 2'h3;
   localparam logic [1:0] RATE_G1    = 2'h1;
   localparam logic [1:0] RATE_G2    = 2'h2;
   localparam logic [1:0] RATE_RSV   = 2'h0;
   // fifo
   localparam int FIFO_DEPTH  = 4;
endpackage

/* hw/pldt_fifo.sv */
`timescale 1ns/1ps
// small synchronous fifo with valid/ready on both sides
module pldt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("fifo depth must be power of two >= 2");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];   // storage
   logic [AW-1:0]    wr_q;            // write pointer
   logic [AW-1:0]    rd_q;            // read pointer
   logic [AW:0]      cnt_q;           // fill level
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign push = ce_i && in_valid_i && in_ready_o;
   assign pop  = ce_i && out_valid_o && out_ready_i;

   // storage write
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // pointers and level
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + AW'(1);
         if (pop)  rd_q <= rd_q + AW'(1);
         if (push && !pop) cnt_q <= cnt_q + (AW+1)'(1);
         else if (pop && !push) cnt_q <= cnt_q - (AW+1)'(1);
      end
   end
endmodule

/* hw/pldt_tap.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pldt_tap #(
   parameter int LANES = pldt_pkg::LANES,
   parameter int DEPTH = pldt_pkg::FIFO_DEPTH
) (
   input  wire logic                                  core_clk_i,
   input  wire logic                                  rst_i,
   input  wire logic                                  ce_i,
   // receive side, from the serial pins domain (synchronised here)
   input  wire logic [LANES*pldt_pkg::DATA_W-1:0]     rx_data_raw_i,
   input  wire logic [LANES*pldt_pkg::K_W-1:0]        rx_k_raw_i,
   input  wire logic [LANES-1:0]                      rx_lock_i,
   input  wire logic [LANES-1:0]                      rx_line_idle_i,
   input  wire logic [LANES*3-1:0]                    rx_event_i,
   input  wire logic [LANES-1:0]                      rx_blk_start_i,
   input  wire logic [LANES*2-1:0]                    rx_sync_hdr_i,
   input  wire logic [LANES-1:0]                      rx_skip_i,
   input  wire logic [LANES-1:0]                      op_done_i,
   // mac side controls and transmit data
   input  wire logic [LANES*pldt_pkg::DATA_W-1:0]     tx_data_i,
   input  wire logic [LANES*pldt_pkg::K_W-1:0]        tx_k_i,
   input  wire logic [LANES-1:0]                      tx_skip_i,
   input  wire logic [LANES*2-1:0]                    tx_sync_hdr_i,
   input  wire logic [LANES-1:0]                      tx_blk_start_i,
   input  wire logic [LANES-1:0]                      det_loop_i,
   input  wire logic [LANES-1:0]                      tx_idle_ctl_i,
   input  wire logic [LANES-1:0]                      compl_ctl_i,
   input  wire logic [LANES-1:0]                      rx_invert_i,
   input  wire logic [LANES*2-1:0]                    pwr_ctl_i,
   input  wire logic [LANES*2-1:0]                    rate_ctl_i,
   // debug consumer
   input  wire logic                                  dbg_ready_i,
   output logic                                       dbg_valid_o,
   output logic [pldt_pkg::DBG_W-1:0]                 dbg_o,
   output logic                                       tap_ready_o,
   // per-lane physical outcome
   output logic [LANES-1:0]                           tx_line_idle_o,
   output logic [LANES-1:0]                           tx_neg_disp_o,
   output logic [LANES-1:0]                           pwr_illegal_o,
   output logic [LANES-1:0]                           rate_reserved_o
);
   localparam int DW = pldt_pkg::DATA_W;
   localparam int KW = pldt_pkg::K_W;
   localparam int BW = pldt_pkg::DBG_W;
   localparam int ST = pldt_pkg::LANE_STRIDE;

   // every check here samples on the core clock and sleeps in reset
   default clocking core_cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   // refuse lane counts whose slices overrun the debug word
   if (LANES < 1 || LANES * ST > BW) begin
      $error("lane count does not fit the debug word");
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for everything arriving from the pins
   localparam int SW = LANES*(DW+KW+1+1+3+1+2+1+1);
   logic [SW-1:0] sync1_q;   // first stage, read only by stage two
   logic [SW-1:0] sync2_q;   // stable copy
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (ce_i) begin
         sync1_q <= {rx_data_raw_i, rx_k_raw_i, rx_lock_i, rx_line_idle_i, rx_event_i,
                     rx_blk_start_i, rx_sync_hdr_i, rx_skip_i, op_done_i};
         sync2_q <= sync1_q;
      end
   end

   logic [LANES*DW-1:0] s_rxd;    // synchronised rx data
   logic [LANES*KW-1:0] s_rxk;    // synchronised k flags
   logic [LANES-1:0]    s_lock;   // symbol lock
   logic [LANES-1:0]    s_idle;   // line idle
   logic [LANES*3-1:0]  s_evt;    // rx status
   logic [LANES-1:0]    s_blk;    // rx block start
   logic [LANES*2-1:0]  s_sh;     // rx sync header
   logic [LANES-1:0]    s_skip;   // rx data skip
   logic [LANES-1:0]    s_done;   // phy operation done level
   assign {s_rxd, s_rxk, s_lock, s_idle, s_evt, s_blk, s_sh, s_skip, s_done} = sync2_q;

   ////////////////////////////////////////////////////////////////////////////
   // per-lane logic: polarity, status, done pulse, debug word assembly
   logic [LANES-1:0] done_prev_q;   // last done level, for the edge pulse
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         done_prev_q <= '0;
      end else if (ce_i) begin
         done_prev_q <= s_done;
      end
   end

   logic [BW-1:0]    word_d;       // assembled debug word
   logic [LANES-1:0] rxvalid_w;    // per-lane rx valid
   logic [LANES-1:0] done_pulse;   // one-cycle completion
   always_comb begin
      word_d = '0;   // unassigned positions stay zero
      for (int l = 0; l < LANES; l++) begin
         // status code copied verbatim; 3'h7 reserved, never produced
         word_d[l*ST+pldt_pkg::POS_RXSTAT +: 3] = s_evt[l*3 +: 3];
         // receive flags from the phy, already synchronised
         word_d[l*ST+pldt_pkg::POS_RXIDLE]     = s_idle[l];
         done_pulse[l] = s_done[l] && !done_prev_q[l];
         word_d[l*ST+pldt_pkg::POS_DONE]       = done_pulse[l];
         rxvalid_w[l] = s_lock[l];
         word_d[l*ST+pldt_pkg::POS_RXVALID]    = rxvalid_w[l];
         word_d[l*ST+pldt_pkg::POS_RXBLK]      = s_blk[l];
         word_d[l*ST+pldt_pkg::POS_RXSYNC +: 2] = s_sh[l*2 +: 2];
         word_d[l*ST+pldt_pkg::POS_RXSKIP]     = s_skip[l];
         // data inverted while polarity asserted; zero without lock
         word_d[l*ST+pldt_pkg::POS_RXDATA +: DW] =
            s_lock[l] ? (s_rxd[l*DW +: DW] ^ {DW{rx_invert_i[l]}}) : '0;
         word_d[l*ST+pldt_pkg::POS_RXK +: KW]  = s_lock[l] ? s_rxk[l*KW +: KW] : '0;
         // transmit data and framing from the mac, same clock
         word_d[l*ST+pldt_pkg::POS_TXDATA +: DW] = tx_data_i[l*DW +: DW];
         word_d[l*ST+pldt_pkg::POS_TXK +: KW]  = tx_k_i[l*KW +: KW];
         word_d[l*ST+pldt_pkg::POS_TXSKIP]     = tx_skip_i[l];
         word_d[l*ST+pldt_pkg::POS_TXSYNC +: 2] = tx_sync_hdr_i[l*2 +: 2];
         word_d[l*ST+pldt_pkg::POS_TXBLK]      = tx_blk_start_i[l];
         // mac lane controls, copied as driven
         word_d[l*ST+pldt_pkg::POS_DETLB]      = det_loop_i[l];
         word_d[l*ST+pldt_pkg::POS_TXIDLE]     = tx_idle_ctl_i[l];
         word_d[l*ST+pldt_pkg::POS_COMPL]      = compl_ctl_i[l];
         word_d[l*ST+pldt_pkg::POS_RXPOL]      = rx_invert_i[l];
         word_d[l*ST+pldt_pkg::POS_PWR +: 2]   = pwr_ctl_i[l*2 +: 2];
         word_d[l*ST+pldt_pkg::POS_RATE +: 2]  = rate_ctl_i[l*2 +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lane outcome flags from the mac controls
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         tx_line_idle_o  <= '1;
         tx_neg_disp_o   <= '0;
         pwr_illegal_o   <= '0;
         rate_reserved_o <= '0;
      end else if (ce_i) begin
         for (int l = 0; l < LANES; l++) begin
            // idle when forced or power state says idle
            tx_line_idle_o[l]  <= tx_idle_ctl_i[l] ||
                                  (pwr_ctl_i[l*2 +: 2] == pldt_pkg::PWR_IDLE);
            tx_neg_disp_o[l]   <= compl_ctl_i[l];
            pwr_illegal_o[l]   <= (pwr_ctl_i[l*2 +: 2] == pldt_pkg::PWR_BAD);
            rate_reserved_o[l] <= (rate_ctl_i[l*2 +: 2] == pldt_pkg::RATE_RSV);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capture stage feeding the fifo
   logic [BW-1:0] cap_q;        // captured debug word
   logic          cap_vld_q;    // capture valid
   logic          fifo_in_rdy;  // fifo accepts
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cap_q     <= '0;
         cap_vld_q <= 1'b0;
      end else if (ce_i) begin
         if (!cap_vld_q || fifo_in_rdy) begin
            cap_q     <= word_d;
            cap_vld_q <= 1'b1;
         end
      end
   end

   logic [BW-1:0] fifo_data;   // fifo head
   logic          fifo_vld;    // fifo non-empty
   logic          out_take;    // output stage may load
   assign out_take = !dbg_valid_o || dbg_ready_i;

   pldt_fifo #(
      .WIDTH (BW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .in_data_i   (cap_q),
      .in_valid_i  (cap_vld_q),
      .in_ready_o  (fifo_in_rdy),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_vld),
      .out_ready_i (out_take)
   );

   // registered output stage
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         dbg_o       <= '0;
         dbg_valid_o <= 1'b0;
         tap_ready_o <= 1'b0;
      end else if (ce_i) begin
         tap_ready_o <= fifo_in_rdy;
         if (out_take) begin
            dbg_o       <= fifo_data;
            dbg_valid_o <= fifo_vld;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // rx valid bit only with symbol lock
   a_valid_needs_lock: assert property (
      word_d[pldt_pkg::POS_RXVALID] |-> s_lock[0])
      else $error("rx valid without lock");
   // completion lasts one enabled cycle
   a_done_one_cycle: assert property (
      ce_i && done_pulse[0] |=> !done_pulse[0] || !ce_i)
      else $error("done pulse too long");
   // lane 0 idle flag position
   a_idle_bit_copy: assert property (
      word_d[pldt_pkg::POS_RXIDLE] == s_idle[0])
      else $error("idle bit misplaced");
   // lane 0 status code position
   a_status_copy: assert property (
      word_d[pldt_pkg::POS_RXSTAT +: 3] == s_evt[2:0])
      else $error("status misplaced");
   // inverted data while polarity asserted
   a_polarity_inv: assert property (
      s_lock[0] && rx_invert_i[0] |-> word_d[pldt_pkg::POS_RXDATA +: DW] == ~s_rxd[DW-1:0])
      else $error("polarity wrong");
   // lane 0 transmit data position
   a_txdata_copy: assert property (
      word_d[pldt_pkg::POS_TXDATA +: DW] == tx_data_i[DW-1:0])
      else $error("tx data misplaced");
   // forced idle reaches the lane flag
   a_idle_force: assert property (
      ce_i && tx_idle_ctl_i[0] |=> tx_line_idle_o[0])
      else $error("tx idle not forced");
   // compliance forces negative disparity
   a_compl_neg: assert property (
      ce_i && compl_ctl_i[0] |=> tx_neg_disp_o[0])
      else $error("disparity not negative");
   // illegal power code flagged
   a_pwr_illegal: assert property (
      ce_i && pwr_ctl_i[1:0] == pldt_pkg::PWR_BAD |=> pwr_illegal_o[0])
      else $error("pwr flag");
   // lane 0 unused bits stay zero
   a_gap_zero: assert property (
      word_d[ST-1:pldt_pkg::POS_RATE+2] == '0)
      else $error("unused bits nonzero");
   // last lane status code position
   a_stat_last: assert property (
      word_d[(LANES-1)*ST+pldt_pkg::POS_RXSTAT +: 3] == s_evt[LANES*3-1 -: 3])
      else $error("last lane status misplaced");
   // last lane completion one cycle
   a_done_last: assert property (
      ce_i && done_pulse[LANES-1] |=> !done_pulse[LANES-1] || !ce_i)
      else $error("last lane done too long");
   // last lane idle flag position
   a_idle_last: assert property (
      word_d[(LANES-1)*ST+pldt_pkg::POS_RXIDLE] == s_idle[LANES-1])
      else $error("last lane idle misplaced");
   // receive block start position
   a_rxblk_copy: assert property (
      word_d[pldt_pkg::POS_RXBLK] == s_blk[0])
      else $error("rx block start misplaced");
   // transmit block start position
   a_txblk_copy: assert property (
      word_d[pldt_pkg::POS_TXBLK] == tx_blk_start_i[0])
      else $error("tx block start misplaced");
   // receive sync header position
   a_rxsync_copy: assert property (
      word_d[pldt_pkg::POS_RXSYNC +: 2] == s_sh[1:0])
      else $error("rx sync header misplaced");
   // transmit sync header position
   a_txsync_copy: assert property (
      word_d[pldt_pkg::POS_TXSYNC +: 2] == tx_sync_hdr_i[1:0])
      else $error("tx sync header misplaced");
   // receive data skip position
   a_rxskip_copy: assert property (
      word_d[pldt_pkg::POS_RXSKIP] == s_skip[0])
      else $error("rx skip misplaced");
   // transmit data skip position
   a_txskip_copy: assert property (
      word_d[pldt_pkg::POS_TXSKIP] == tx_skip_i[0])
      else $error("tx skip misplaced");
   // control flags follow the data under lock
   a_rxk_copy: assert property (
      s_lock[0] |-> word_d[pldt_pkg::POS_RXK +: KW] == s_rxk[KW-1:0])
      else $error("rx control flags misplaced");
   // no lock, no receive data
   a_nolock_zero: assert property (
      !s_lock[0] |-> word_d[pldt_pkg::POS_RXDATA +: DW] == '0)
      else $error("rx data without lock");
   // transmit control flags position
   a_txk_copy: assert property (
      word_d[pldt_pkg::POS_TXK +: KW] == tx_k_i[KW-1:0])
      else $error("tx control flags misplaced");
   // power-down field position
   a_pwr_copy: assert property (
      word_d[pldt_pkg::POS_PWR +: 2] == pwr_ctl_i[1:0])
      else $error("power field misplaced");
   // idle power state idles the line
   a_pwr_idle: assert property (
      ce_i && pwr_ctl_i[1:0] == pldt_pkg::PWR_IDLE |=> tx_line_idle_o[0])
      else $error("power idle not shown");
   // polarity control position
   a_rxpol_copy: assert property (
      word_d[pldt_pkg::POS_RXPOL] == rx_invert_i[0])
      else $error("polarity bit misplaced");
   // compliance control position
   a_compl_copy: assert property (
      word_d[pldt_pkg::POS_COMPL] == compl_ctl_i[0])
      else $error("compliance bit misplaced");
   // transmit idle control position
   a_txidle_copy: assert property (
      word_d[pldt_pkg::POS_TXIDLE] == tx_idle_ctl_i[0])
      else $error("tx idle bit misplaced");
   // detect or loopback control position
   a_detlb_copy: assert property (
      word_d[pldt_pkg::POS_DETLB] == det_loop_i[0])
      else $error("detect bit misplaced");
   // rate field position
   a_rate_copy: assert property (
      word_d[pldt_pkg::POS_RATE +: 2] == rate_ctl_i[1:0])
      else $error("rate field misplaced");
   // reserved rate code flagged
   a_rate_rsv: assert property (
      ce_i && rate_ctl_i[1:0] == pldt_pkg::RATE_RSV |=> rate_reserved_o[0])
      else $error("reserved rate not flagged");
   // bits above the last lane stay zero
   a_gap_last: assert property (
      word_d[BW-1:(LANES-1)*ST+pldt_pkg::POS_RATE+2] == '0)
      else $error("upper bits nonzero");
   // stalled output word holds
   a_out_hold: assert property (
      ce_i && dbg_valid_o && !dbg_ready_i |=> $stable(dbg_o) && dbg_valid_o)
      else $error("output word not held");
endmodule

/* verification/pldt_phy_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// behavioural phy/pcs pair of lanes, drives the pin-domain receive side
module pldt_phy_model (
   input  wire logic        core_clk_i,
   output logic [63:0]      rx_data_raw_o,
   output logic [7:0]       rx_k_raw_o,
   output logic [1:0]       rx_lock_o,
   output logic [1:0]       rx_line_idle_o,
   output logic [5:0]       rx_event_o,
   output logic [1:0]       rx_blk_start_o,
   output logic [3:0]       rx_sync_hdr_o,
   output logic [1:0]       rx_skip_o,
   output logic [1:0]       op_done_o
);
   // quiet lanes until the bench asks for traffic
   initial begin
      {rx_data_raw_o, rx_k_raw_o, rx_lock_o, rx_line_idle_o, rx_event_o} = '0;
      {rx_blk_start_o, rx_sync_hdr_o, rx_skip_o, op_done_o} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one lane's receive state, held until the next call except the data while lock is low
   task automatic set_lane(input int l, input logic [31:0] d, input logic [3:0] k,
                           input logic lk, input logic idl, input logic [2:0] st,
                           input logic blk, input logic [1:0] sh, input logic skp);
      rx_data_raw_o[l*32 +: 32] = d;
      rx_k_raw_o[l*4 +: 4]      = k;
      rx_lock_o[l]              = lk;
      rx_line_idle_o[l]         = idl;
      rx_event_o[l*3 +: 3]      = st;
      rx_blk_start_o[l]         = blk;
      rx_sync_hdr_o[l*2 +: 2]   = sh;
      rx_skip_o[l]              = skp;
   endtask
   // completion level; the tap turns its rise into a pulse
   task automatic set_done(input int l, input logic v);
      op_done_o[l] = v;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // without symbol lock the data lines carry garbage that changes every cycle
   always @(negedge core_clk_i) begin
      for (int l = 0; l < 2; l++) begin
         if (!rx_lock_o[l]) begin
            rx_data_raw_o[l*32 +: 32] = ~rx_data_raw_o[l*32 +: 32];
         end
      end
   end
endmodule

/* verification/pipe_lane_debug_tap_test.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the lane debug tap
module pipe_lane_debug_tap_test;
   logic         core_clk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic         ce_i = 1'b1;
   logic         dbg_ready_i = 1'b0;
   logic [63:0]  rx_data_raw_i, tx_data_i = '0;
   logic [7:0]   rx_k_raw_i, tx_k_i = '0;
   logic [5:0]   rx_event_i;
   logic [3:0]   rx_sync_hdr_i, tx_sync_hdr_i = '0, pwr_ctl_i = '0, rate_ctl_i = '0;
   logic [1:0]   rx_lock_i, rx_line_idle_i, rx_blk_start_i, rx_skip_i, op_done_i;
   logic [1:0]   tx_skip_i = '0, tx_blk_start_i = '0, det_loop_i = '0, tx_idle_ctl_i = '0;
   logic [1:0]   compl_ctl_i = '0, rx_invert_i = '0;
   logic [1:0]   tx_line_idle_o, tx_neg_disp_o, pwr_illegal_o, rate_reserved_o;
   logic         dbg_valid_o, tap_ready_o;
   logic [319:0] dbg_o, w;
   int           mismatches = 0;
   int           compares = 0;
   // 100 ns clock
   initial begin
      forever #50 core_clk_i = ~core_clk_i;
   end
   pldt_phy_model i_phy (.core_clk_i, .rx_data_raw_o(rx_data_raw_i), .rx_k_raw_o(rx_k_raw_i),
      .rx_lock_o(rx_lock_i), .rx_line_idle_o(rx_line_idle_i), .rx_event_o(rx_event_i),
      .rx_blk_start_o(rx_blk_start_i), .rx_sync_hdr_o(rx_sync_hdr_i),
      .rx_skip_o(rx_skip_i), .op_done_o(op_done_i));
   pldt_tap #(.LANES(2), .DEPTH(4)) i_dut (.core_clk_i, .rst_i, .ce_i, .rx_data_raw_i,
      .rx_k_raw_i, .rx_lock_i, .rx_line_idle_i, .rx_event_i, .rx_blk_start_i, .rx_sync_hdr_i,
      .rx_skip_i, .op_done_i, .tx_data_i, .tx_k_i, .tx_skip_i, .tx_sync_hdr_i, .tx_blk_start_i,
      .det_loop_i, .tx_idle_ctl_i, .compl_ctl_i, .rx_invert_i, .pwr_ctl_i, .rate_ctl_i,
      .dbg_ready_i, .dbg_valid_o, .dbg_o, .tap_ready_o, .tx_line_idle_o, .tx_neg_disp_o,
      .pwr_illegal_o, .rate_reserved_o);
   ////////////////////////////////////////////////////////////////////////////////
   // helpers: cycle, compare, verdict, bounded wait
   task automatic cyc();
      @(negedge core_clk_i);
   endtask
   task automatic summarize();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [319:0] got, input logic [319:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   // p below 320 watches a debug bit, 320 watches tap_ready_o
   task automatic wait_lvl(input int p, input logic v);
      int n;
      n = 0;
      while (((p < 320) ? dbg_o[p] : tap_ready_o) !== v && n < 12) begin
         cyc();
         n++;
      end
      if (n == 12) begin
         mismatches++;
         $display("unexpected at %0t: wait ran out", $time);
         summarize();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // stimulus pattern j on lane l, both sides of the lane
   task automatic drive(input int l, input int j);
      logic [2:0] b;
      b = 3'(j);
      i_phy.set_lane(l, 32'hA5C30F00 + 32'(j), 4'(j), j != 3, b[0], 3'(j % 7), b[1],
                     b[0] ? pldt_pkg::SYNC_OS : pldt_pkg::SYNC_DATA, b[1]);
      tx_data_i[l*32 +: 32] = 32'h12345600 | 32'(j);
      tx_k_i[l*4 +: 4] = ~4'(j);
      tx_skip_i[l] = b[0];
      tx_sync_hdr_i[l*2 +: 2] = b[1] ? pldt_pkg::SYNC_OS : pldt_pkg::SYNC_DATA;
      tx_blk_start_i[l] = b[2];
      det_loop_i[l] = b[0];
      tx_idle_ctl_i[l] = b[2] & b[0];
      compl_ctl_i[l] = b[1];
      rx_invert_i[l] = b[0];
      pwr_ctl_i[l*2 +: 2] = b[1:0];
      rate_ctl_i[l*2 +: 2] = 2'(j % 3);
   endtask
   // expected 160-bit lane slice for pattern j
   function automatic logic [159:0] exp_lane(input int j);
      logic [159:0] e;
      logic [2:0]   b;
      logic [31:0]  d;
      b = 3'(j);
      d = (b[0] ? ~(32'hA5C30F00 + 32'(j)) : 32'hA5C30F00 + 32'(j));
      e = '0;
      e[pldt_pkg::POS_TXDATA +: 32] = 32'h12345600 | 32'(j);
      e[pldt_pkg::POS_TXK +: 4] = ~4'(j);
      e[pldt_pkg::POS_TXSKIP] = b[0];
      e[pldt_pkg::POS_TXSYNC +: 2] = b[1] ? pldt_pkg::SYNC_OS : pldt_pkg::SYNC_DATA;
      e[pldt_pkg::POS_TXBLK] = b[2];
      e[pldt_pkg::POS_DETLB] = b[0];
      e[pldt_pkg::POS_TXIDLE] = b[2] & b[0];
      e[pldt_pkg::POS_COMPL] = b[1];
      e[pldt_pkg::POS_RXPOL] = b[0];
      e[pldt_pkg::POS_PWR +: 2] = b[1:0];
      e[pldt_pkg::POS_RXDATA +: 32] = (j != 3) ? d : 32'h0;
      e[pldt_pkg::POS_RXK +: 4] = (j != 3) ? 4'(j) : 4'h0;
      e[pldt_pkg::POS_RXSKIP] = b[1];
      e[pldt_pkg::POS_RXSYNC +: 2] = b[0] ? pldt_pkg::SYNC_OS : pldt_pkg::SYNC_DATA;
      e[pldt_pkg::POS_RXBLK] = b[1];
      e[pldt_pkg::POS_RXVALID] = (j != 3);
      e[pldt_pkg::POS_RXIDLE] = b[0];
      e[pldt_pkg::POS_RXSTAT +: 3] = 3'(j % 7);
      e[pldt_pkg::POS_RATE +: 2] = 2'(j % 3);
      return e;
   endfunction
   // registered per-lane outcome for pattern j
   task automatic side_chk(input int l, input int j);
      logic [2:0] b;
      b = 3'(j);
      chk(tx_line_idle_o[l], (b[2] & b[0]) | (b[1:0] == 2'h1), "tx idle");
      chk(tx_neg_disp_o[l], b[1], "neg disparity");
      chk(pwr_illegal_o[l], b[1:0] == 2'h3, "power illegal");
      chk(rate_reserved_o[l], j % 3 == 0, "rate reserved");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (6) @(posedge core_clk_i);
      cyc();
      chk(tx_line_idle_o, 2'h3, "reset tx idle");
      chk(dbg_valid_o, 1'b0, "reset valid");
      rst_i = 1'b0;
      dbg_ready_i = 1'b1;
      // every status, sync, power and rate code; lock lost and inversion on the way
      for (int i = 0; i < 7; i++) begin
         drive(0, i);
         drive(1, i + 1);
         repeat (10) cyc();
         chk(dbg_o, {exp_lane(i + 1), exp_lane(i)}, "debug word");
         side_chk(0, i);
         side_chk(1, i + 1);
      end
      // clock enable low freezes every register while inputs move
      ce_i = 1'b0;
      w = dbg_o;
      drive(0, 5);
      drive(1, 2);
      repeat (8) cyc();
      chk(dbg_o, w, "frozen word");
      side_chk(0, 6);
      ce_i = 1'b1;
      repeat (10) cyc();
      chk(dbg_o, {exp_lane(2), exp_lane(5)}, "word after freeze");
      side_chk(0, 5);
      // completion is one cycle wide on each lane
      for (int l = 0; l < 2; l++) begin
         i_phy.set_done(l, 1'b1);
         wait_lvl(l * 160 + pldt_pkg::POS_DONE, 1'b1);
         cyc();
         chk(dbg_o[l*160+pldt_pkg::POS_DONE], 1'b0, "done width");
         i_phy.set_done(l, 1'b0);
      end
      // consumer stalls: fifo fills, word holds, then drains
      dbg_ready_i = 1'b0;
      wait_lvl(320, 1'b0);
      w = dbg_o;
      drive(0, 4);
      drive(1, 0);
      repeat (3) cyc();
      chk(dbg_o, w, "held word");
      chk(dbg_valid_o, 1'b1, "held valid");
      chk(tap_ready_o, 1'b0, "full fifo");
      dbg_ready_i = 1'b1;
      wait_lvl(320, 1'b1);
      repeat (10) cyc();
      chk(dbg_o, {exp_lane(0), exp_lane(4)}, "word after drain");
      // a second reset mid-run clears the pipeline and idles the lanes
      rst_i = 1'b1;
      repeat (2) cyc();
      chk(dbg_valid_o, 1'b0, "valid after reset");
      chk(tx_line_idle_o, 2'h3, "idle after reset");
      rst_i = 1'b0;
      repeat (10) cyc();
      chk(dbg_o, {exp_lane(0), exp_lane(4)}, "word after reset");
      summarize();
   end
endmodule
